// ### logic/rov_delay_timer.v
`timescale 1ns/100ps
`default_nettype none
`include "rov_map.vh"

module rov_delay_timer #(
  parameter integer CYCLES_PER_MS = `ROV_CYCLES_PER_MS,
  parameter integer PRE_W = 16
) (
  input wire pclk,
  input wire presetn,
  input wire run,
  input wire [15:0] delay_ms,
  output reg expired
);

  reg [PRE_W-1:0] pre_reg;
  reg [15:0] ms_reg;

  // Count is cleared whenever run drops, so each pickup times from zero
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pre_reg <= {PRE_W{1'b0}};
      ms_reg <= 16'h0000;
      expired <= 1'b0;
    end else if (!run) begin
      pre_reg <= {PRE_W{1'b0}};
      ms_reg <= 16'h0000;
      expired <= 1'b0;
    end else begin
      if (pre_reg == CYCLES_PER_MS[PRE_W-1:0] - {{(PRE_W-1){1'b0}}, 1'b1}) begin
        pre_reg <= {PRE_W{1'b0}};
        // Saturates, so a long start never wraps into a false short delay
        if (ms_reg != 16'hFFFF) begin
          ms_reg <= ms_reg + 16'h0001;
        end
      end else begin
        pre_reg <= pre_reg + {{(PRE_W-1){1'b0}}, 1'b1};
      end
      expired <= (ms_reg >= delay_ms);
    end
  end

endmodule // rov_delay_timer

`default_nettype wire

// ### logic/rov_map.vh
// Behaviour
// - Once the residual magnitude is above pickup, the operate time is the delay setting alone, whatever the overshoot.
// - The only measured input is the RMS magnitude of the residual voltage fundamental, made outside this block.
// - Pickup level is a percent setting from 2 to 60 in steps of one, default 30.
// - Definite delay is a millisecond setting from 0 to 60000 in steps of one, default 100.
// - Start is asserted while the magnitude exceeds pickup, and the delay runs only while that persists.
// - The characteristic stage decides start and times the delay, raising the delayed trip once it elapses with start active.
// - An operation selector Off/On, default On; when Off neither start nor trip is asserted.
// - A start-only setting, default false; when true starts are reported but the general trip is suppressed.
// - The general trip is formed from start and delayed trip, gated by start-only and the operation selector.
// - A blocking input from user logic disables the whole function and holds its outputs inactive.
// - A general start output reflects the started state.
// - A general trip output carries the trip command of the decision stage.
`ifndef ROV_MAP_VH
`define ROV_MAP_VH

`define ROV_ADDR_CTRL 8'h00
`define ROV_ADDR_PICKUP 8'h04
`define ROV_ADDR_DELAY 8'h08
`define ROV_ADDR_STATUS 8'h0C
`define ROV_ADDR_IRQ_STAT 8'h10
`define ROV_ADDR_IRQ_MASK 8'h14
`define ROV_ADDR_RATED 8'h18

`define ROV_CTRL_OPER_BIT 0
`define ROV_CTRL_STONLY_BIT 1
`define ROV_OPER_RST 1'b1
`define ROV_STONLY_RST 1'b0

`define ROV_PICKUP_MIN 7'h02
`define ROV_PICKUP_MAX 7'h3C
`define ROV_PICKUP_RST 7'h1E
`define ROV_PERCENT_FULL 7'h64

`define ROV_DELAY_MIN 16'h0000
`define ROV_DELAY_MAX 16'hEA60
`define ROV_DELAY_RST 16'h0064

`define ROV_RATED_RST 16'h4000

`define ROV_ST_START_BIT 0
`define ROV_ST_DTRIP_BIT 1
`define ROV_ST_GSTART_BIT 2
`define ROV_ST_GTRIP_BIT 3
`define ROV_ST_BLOCK_BIT 4

`define ROV_IRQ_START_BIT 0
`define ROV_IRQ_TRIP_BIT 1
`define ROV_IRQ_W 2

`define ROV_CLK_HZ 50000000
`define ROV_TICK_MS 1
`define ROV_CYCLES_PER_MS (`ROV_CLK_HZ / 1000 * `ROV_TICK_MS)

`endif

// ### logic/rov_residual_overvoltage.v
`timescale 1ns/100ps
`default_nettype none
`include "rov_map.vh"

module rov_residual_overvoltage #(
  parameter integer MAG_W = 16,
  parameter integer CYCLES_PER_MS = `ROV_CYCLES_PER_MS
) (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [7:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  input wire [MAG_W-1:0] residual_rms_magnitude,
  input wire block_input,
  output reg general_start_out,
  output reg general_trip_out,
  output reg irq
);

  localparam integer PROD_W = MAG_W + 8;

  reg operation_select_reg;
  reg start_only_select_reg;
  reg [6:0] pickup_level_percent_reg;
  reg [15:0] definite_delay_ms_reg;
  reg [15:0] rated_reg;
  reg [`ROV_IRQ_W-1:0] irq_stat_reg;
  reg [`ROV_IRQ_W-1:0] irq_mask_reg;
  reg start_flag_reg;
  reg start_prev_reg;
  reg trip_prev_reg;

  wire delayed_trip_flag;
  wire enabled;
  wire [PROD_W-1:0] mag_scaled;
  wire [PROD_W-1:0] pickup_scaled;
  wire over_pickup;
  wire gen_trip_next;
  wire wr_en;
  wire rd_en;
  wire addr_ok;
  wire [31:0] wdata_pickup;
  wire [31:0] wdata_delay;
  wire [`ROV_IRQ_W-1:0] irq_events;
  reg [31:0] rdata_next;

  // Function is live only when switched on and not blocked
  assign enabled = operation_select_reg & ~block_input;

  // Both sides scaled to magnitude x 100, so percent and rated value share one scale
  assign mag_scaled = {{(PROD_W-MAG_W){1'b0}}, residual_rms_magnitude} * `ROV_PERCENT_FULL;
  assign pickup_scaled = {{(PROD_W-7){1'b0}}, pickup_level_percent_reg} * {{(PROD_W-16){1'b0}}, rated_reg};
  assign over_pickup = enabled & (mag_scaled > pickup_scaled);

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      start_flag_reg <= 1'b0;
    end else begin
      start_flag_reg <= over_pickup;
    end
  end

  // Timer runs only while start holds; dropping start clears it
  rov_delay_timer #(
    .CYCLES_PER_MS(CYCLES_PER_MS),
    .PRE_W(16)
  ) u_timer (
    .pclk(pclk),
    .presetn(presetn),
    .run(over_pickup & start_flag_reg),
    .delay_ms(definite_delay_ms_reg),
    .expired(delayed_trip_flag)
  );

  // Trip needs start still active when the delay ends
  assign gen_trip_next = start_flag_reg & delayed_trip_flag & over_pickup & ~start_only_select_reg;

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      general_start_out <= 1'b0;
      general_trip_out <= 1'b0;
    end else begin
      general_start_out <= start_flag_reg & over_pickup;
      general_trip_out <= gen_trip_next;
    end
  end

  // APB: one wait state, pready comes from a flop
  assign wr_en = psel & penable & pready & pwrite;
  assign rd_en = psel & penable & ~pready & ~pwrite;
  assign addr_ok = (paddr == `ROV_ADDR_CTRL) | (paddr == `ROV_ADDR_PICKUP) | (paddr == `ROV_ADDR_DELAY) |
                   (paddr == `ROV_ADDR_STATUS) | (paddr == `ROV_ADDR_IRQ_STAT) |
                   (paddr == `ROV_ADDR_IRQ_MASK) | (paddr == `ROV_ADDR_RATED);

  // Out-of-range settings are clamped rather than refused, so the relay never runs unprotected
  assign wdata_pickup = (pwdata < {{25{1'b0}}, `ROV_PICKUP_MIN}) ? {{25{1'b0}}, `ROV_PICKUP_MIN} :
                        (pwdata > {{25{1'b0}}, `ROV_PICKUP_MAX}) ? {{25{1'b0}}, `ROV_PICKUP_MAX} : pwdata;
  assign wdata_delay = (pwdata > {16'h0000, `ROV_DELAY_MAX}) ? {16'h0000, `ROV_DELAY_MAX} : pwdata;

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end else begin
      pready <= psel & penable & ~pready;
      pslverr <= psel & penable & ~pready & ~addr_ok;
      if (rd_en) begin
        prdata <= rdata_next;
      end
    end
  end

  always @* begin
    rdata_next = 32'h0000_0000;
    case (paddr)
      `ROV_ADDR_CTRL: begin
        rdata_next[`ROV_CTRL_OPER_BIT] = operation_select_reg;
        rdata_next[`ROV_CTRL_STONLY_BIT] = start_only_select_reg;
      end
      `ROV_ADDR_PICKUP: begin
        rdata_next[6:0] = pickup_level_percent_reg;
      end
      `ROV_ADDR_DELAY: begin
        rdata_next[15:0] = definite_delay_ms_reg;
      end
      `ROV_ADDR_STATUS: begin
        rdata_next[`ROV_ST_START_BIT] = start_flag_reg;
        rdata_next[`ROV_ST_DTRIP_BIT] = delayed_trip_flag;
        rdata_next[`ROV_ST_GSTART_BIT] = general_start_out;
        rdata_next[`ROV_ST_GTRIP_BIT] = general_trip_out;
        rdata_next[`ROV_ST_BLOCK_BIT] = block_input;
      end
      `ROV_ADDR_IRQ_STAT: begin
        rdata_next[`ROV_IRQ_W-1:0] = irq_stat_reg;
      end
      `ROV_ADDR_IRQ_MASK: begin
        rdata_next[`ROV_IRQ_W-1:0] = irq_mask_reg;
      end
      `ROV_ADDR_RATED: begin
        rdata_next[15:0] = rated_reg;
      end
      default: begin
        rdata_next = 32'h0000_0000;
      end
    endcase
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      operation_select_reg <= `ROV_OPER_RST;
      start_only_select_reg <= `ROV_STONLY_RST;
      pickup_level_percent_reg <= `ROV_PICKUP_RST;
      definite_delay_ms_reg <= `ROV_DELAY_RST;
      rated_reg <= `ROV_RATED_RST;
      irq_mask_reg <= {`ROV_IRQ_W{1'b0}};
    end else if (wr_en) begin
      case (paddr)
        `ROV_ADDR_CTRL: begin
          operation_select_reg <= pwdata[`ROV_CTRL_OPER_BIT];
          start_only_select_reg <= pwdata[`ROV_CTRL_STONLY_BIT];
        end
        `ROV_ADDR_PICKUP: begin
          pickup_level_percent_reg <= wdata_pickup[6:0];
        end
        `ROV_ADDR_DELAY: begin
          definite_delay_ms_reg <= wdata_delay[15:0];
        end
        `ROV_ADDR_IRQ_MASK: begin
          irq_mask_reg <= pwdata[`ROV_IRQ_W-1:0];
        end
        `ROV_ADDR_RATED: begin
          rated_reg <= pwdata[15:0];
        end
        default: begin
          rated_reg <= rated_reg;
        end
      endcase
    end
  end

  // Rising edges of the two outputs are the interrupt events
  assign irq_events = {general_trip_out & ~trip_prev_reg, general_start_out & ~start_prev_reg};

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      start_prev_reg <= 1'b0;
      trip_prev_reg <= 1'b0;
      irq_stat_reg <= {`ROV_IRQ_W{1'b0}};
      irq <= 1'b0;
    end else begin
      start_prev_reg <= general_start_out;
      trip_prev_reg <= general_trip_out;
      // A new event in the clearing cycle survives the clear
      if (wr_en && paddr == `ROV_ADDR_IRQ_STAT) begin
        irq_stat_reg <= (irq_stat_reg & ~pwdata[`ROV_IRQ_W-1:0]) | irq_events;
      end else begin
        irq_stat_reg <= irq_stat_reg | irq_events;
      end
      irq <= |(irq_stat_reg & irq_mask_reg);
    end
  end

endmodule // rov_residual_overvoltage

`default_nettype wire

// ### sim/rov_mag_source.sv
`timescale 1ns/100ps
`default_nettype none
module rov_mag_source #(parameter integer MAG_W = 16) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [MAG_W-1:0] level,
  output logic [MAG_W-1:0] magnitude
);
  // Zero during reset so the block never sees a stale fault level
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      magnitude <= {MAG_W{1'b0}};
    end else begin
      magnitude <= level;
    end
  end
endmodule // rov_mag_source
`default_nettype wire

// ### sim/rov_residual_overvoltage_properties.sv
`timescale 1ns/100ps
`default_nettype none
module rov_checker (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic block_input,
  input wire logic general_start_out,
  input wire logic general_trip_out
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence setup_s;
    psel && !penable;
  endsequence
  sequence access_s;
    psel && penable;
  endsequence
  a_ready_wait: assert property (setup_s ##1 access_s |-> !pready ##1 pready) else $error("pready latency");
  a_ready_pulse: assert property (pready |=> !pready) else $error("pready too long");
  a_err_ready: assert property (pslverr |-> pready) else $error("pslverr without pready");
  a_ready_access: assert property (pready |-> access_s) else $error("pready outside access");
  a_idle_ready: assert property (!psel |-> !pready) else $error("pready while idle");
  a_block_quiet: assert property (block_input [*3] |-> !general_start_out && !general_trip_out) else $error("blocked");
  a_start_first: assert property ($rose(general_trip_out) |-> general_start_out) else $error("trip before start");
  a_trip_later: assert property ($rose(general_start_out) |-> !general_trip_out) else $error("trip with start");
endmodule // rov_checker
bind rov_residual_overvoltage rov_checker i_chk (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pready(pready), .pslverr(pslverr), .block_input(block_input), .general_start_out(general_start_out),
  .general_trip_out(general_trip_out));
`default_nettype wire

// ### sim/rov_residual_overvoltage_tb.sv
`timescale 1ns/100ps
`default_nettype none
`include "rov_map.vh"
module rov_residual_overvoltage_tb;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, block_input = 0, er, st;
  logic [7:0] paddr = 0;
  logic [31:0] pwdata = 0, rd;
  logic [15:0] level = 0;
  wire [31:0] prdata;
  wire [15:0] mag;
  wire pready, pslverr, general_start_out, general_trip_out, irq;
  int n_errors = 0, checks_done = 0, p, t, t1;
  logic [7:0] ca [4] = '{`ROV_ADDR_PICKUP, `ROV_ADDR_PICKUP, `ROV_ADDR_DELAY, `ROV_ADDR_PICKUP};
  int cv [4] = '{1, 61, 60001, 0};
  localparam int CPM = 4;
  rov_mag_source #(.MAG_W(16)) i_src (.pclk(pclk), .presetn(presetn), .level(level), .magnitude(mag));
  rov_residual_overvoltage #(.MAG_W(16), .CYCLES_PER_MS(CPM)) i_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .residual_rms_magnitude(mag), .block_input(block_input),
    .general_start_out(general_start_out), .general_trip_out(general_trip_out), .irq(irq));
  always #10 pclk = ~pclk;
  function automatic int clamp_exp(logic [7:0] a, int v);
    if (a == `ROV_ADDR_PICKUP) return (v < 2) ? 2 : (v > 60) ? 60 : v;
    return (v > 60000) ? 60000 : v;
  endfunction
  // Source stage, start flag, timer compare and trip register add four cycles to the counted delay
  function automatic int trip_lat(int d);
    return d * CPM + 4;
  endfunction
  task automatic print_verdict;
    if (n_errors == 0 && checks_done > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_errors++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic apb(input logic wr, input logic [7:0] a, input int d);
    int k;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 20);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (k >= 20) begin
      n_errors++;
      print_verdict();
    end
  endtask
  // Fixed window, long enough for the set delay plus pipeline
  task automatic run(input int m);
    int k;
    @(posedge pclk);
    level <= m[15:0];
    st = 0;
    t = 99;
    for (k = 0; k < 40; k++) begin
      @(posedge pclk);
      if (general_start_out === 1'b1) st = 1;
      if (general_trip_out === 1'b1 && t == 99) t = k;
    end
    level <= 16'h0000;
    repeat (4) @(posedge pclk);
  endtask
  initial begin
    void'($urandom(32'hf18c));
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    apb(0, `ROV_ADDR_CTRL, 0);
    chk("ctrl", rd, 32'h0000_0001);
    apb(0, `ROV_ADDR_PICKUP, 0);
    chk("pickup", rd, 32'h0000_001E);
    apb(0, `ROV_ADDR_DELAY, 0);
    chk("delay", rd, 32'h0000_0064);
    apb(0, 8'h1C, 0);
    chk("unmapped", er, 32'h0000_0001);
    cv[3] = 2 + ($urandom % 59);
    for (int i = 0; i < 4; i++) begin
      apb(1, ca[i], cv[i]);
      apb(0, ca[i], 0);
      chk("clamp", rd, clamp_exp(ca[i], cv[i]));
    end
    p = cv[3];
    apb(1, `ROV_ADDR_RATED, 1000);
    apb(1, `ROV_ADDR_DELAY, 2);
    apb(1, `ROV_ADDR_IRQ_MASK, 3);
    apb(0, `ROV_ADDR_RATED, 0);
    chk("rated", rd, 32'h0000_03E8);
    apb(0, `ROV_ADDR_IRQ_MASK, 0);
    chk("irq mask", rd, 32'h0000_0003);
    run(p * 10);
    chk("equal level", st, 0);
    run(p * 10 + 1);
    t1 = t;
    chk("start", st, 1);
    chk("delay held", t1, trip_lat(2));
    run(p * 10 + 1 + ($urandom % 5000));
    chk("overshoot time", t, t1);
    chk("irq", irq, 1);
    apb(0, `ROV_ADDR_IRQ_STAT, 0);
    chk("irq stat", rd, 32'h0000_0003);
    apb(1, `ROV_ADDR_IRQ_STAT, 3);
    apb(0, `ROV_ADDR_IRQ_STAT, 0);
    chk("irq clear", irq, 0);
    @(posedge pclk);
    level <= 16'hFFFF;
    repeat (5) @(posedge pclk);
    run(0);
    run(p * 10 + 1);
    chk("restart", t, t1);
    apb(1, `ROV_ADDR_CTRL, 3);
    run(16'hFFFF);
    chk("only start", {st, t == 99}, 2'b11);
    apb(1, `ROV_ADDR_CTRL, 0);
    run(16'hFFFF);
    chk("off", {st, t == 99}, 2'b01);
    apb(1, `ROV_ADDR_CTRL, 1);
    block_input <= 1'b1;
    run(16'hFFFF);
    chk("blocked", {st, t == 99}, 2'b01);
    apb(1, `ROV_ADDR_STATUS, 32'h0000_000F);
    apb(0, `ROV_ADDR_STATUS, 0);
    chk("status", rd, 32'h0000_0010);
    block_input <= 1'b0;
    apb(1, `ROV_ADDR_DELAY, 0);
    run(16'hFFFF);
    chk("zero delay", t, trip_lat(0));
    print_verdict();
  end
endmodule // rov_residual_overvoltage_tb
`default_nettype wire
